// >>> common/marker_pkg.sv
package marker_pkg;
	localparam int NMARK = 4;
	localparam int NSEG = 4;
	localparam int NSAMP = 64;
	localparam int POS_W = 6;
	localparam int SEG_W = 2;
	localparam int IDX_W = 8;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_EDIT = 8'h04;
	localparam logic [7:0] OFF_RANGE = 8'h08;
	localparam logic [7:0] OFF_SEGLEN = 8'h0c;
	localparam logic [7:0] OFF_SEQ = 8'h10;
	localparam logic [7:0] OFF_RES = 8'h14;
	localparam logic [7:0] OFF_STAT = 8'h18;
	// field positions
	localparam int CTRL_PLAY = 0;
	localparam int CTRL_SEQ = 1;
	localparam int CTRL_SEG = 2;
	localparam int CTRL_POL = 4;
	localparam int CTRL_ROUTE = 8;
	localparam int EDIT_CMD = 0;
	localparam int EDIT_MARK = 2;
	localparam int EDIT_SEG = 4;
	localparam int RANGE_FIRST = 0;
	localparam int RANGE_LAST = 8;
	localparam int RANGE_SKIP = 16;
	localparam int SEGLEN_STEP = 8;
	localparam int SEQ_LAST = 0;
	localparam int SEQ_EN = 4;
	localparam int STAT_BUSY = 0;
	localparam int STAT_REFUSED = 1;
	localparam int STAT_SEG = 4;
	localparam int STAT_POS = 8;
	localparam int STAT_EVT = 16;
	// reset values and other constants
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] RANGE_RST = 32'h0000_0000;
	localparam logic [31:0] SEGLEN_RST = 32'h3f3f_3f3f;
	localparam logic [SEG_W-1:0] SEQ_LAST_RST = 2'h0;
	localparam logic [NSEG*NMARK-1:0] SEQ_EN_RST = 16'hffff;
	localparam logic [NSEG-1:0] RES_RST = 4'hf;
	localparam logic [POS_W-1:0] POS_FIRST = 6'h00;
	localparam logic [POS_W-1:0] POS_MAX = 6'h3f;
	localparam logic [NMARK-1:0] ALL_MARK = 4'hf;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;
	typedef enum logic [1:0] {
		CMD_SET_RANGE = 2'h0,
		CMD_CLR_RANGE = 2'h1,
		CMD_CLR_ALL = 2'h2,
		CMD_SET_FIRST = 2'h3
	} cmd_t;
	typedef enum logic [1:0] {
		ED_IDLE = 2'b01,
		ED_RUN = 2'b10
	} ed_state_t;
endpackage

// >>> common/mark_if.sv
`timescale 1ns/1ps
interface mark_if;
	logic valid;
	logic [marker_pkg::NMARK-1:0] bits;
	logic [marker_pkg::NMARK-1:0] en;
	logic [marker_pkg::NMARK-1:0] pol;
	logic [marker_pkg::NMARK-1:0] route;
	modport src (output valid, output bits, output en, output pol,
		output route);
	modport sink (input valid, input bits, input en, input pol,
		input route);
endinterface

// >>> core/marker_out.sv
`timescale 1ns/1ps
module marker_out (
	// clock, reset, freeze
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic ce,
	// marker bits from the store
	mark_if.sink m,
	// event outputs and level-hold sample window
	output logic [marker_pkg::NMARK-1:0] evt,
	output logic alc_sample
);
	logic [marker_pkg::NMARK-1:0] act;
	logic [marker_pkg::NMARK-1:0] lvl;
	logic [marker_pkg::NMARK-1:0] evt_q;
	logic hold_q;

	// enable first, then polarity; idle output stays low
	assign act = m.bits & m.en;
	assign lvl = m.valid ? (act ^ m.pol) : '0;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			evt_q <= '0;
			hold_q <= 1'b0;
		end else if (ce) begin
			evt_q <= lvl;
			hold_q <= |(lvl & m.route);
		end
	end
	assign evt = evt_q;
	assign alc_sample = hold_q;

	neg_pol_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ce && m.valid && m.pol[0] && m.en[0] |=> evt[0] == !$past(m.bits[0]))
		else $error("negative marker level wrong");
	seg_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ce && m.valid && !m.en[1] |=> evt[1] == $past(m.pol[1]))
		else $error("disabled marker not inactive");
	idle_low_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ce && !m.valid |=> evt == '0)
		else $error("idle event output not low");
	hold_win_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ce && m.valid && m.route == 4'h1 |=> alc_sample == evt[0])
		else $error("hold window not tied to marker level");
endmodule

// >>> core/marker_gen.sv
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
module marker_gen (
	// clock, reset, freeze
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic ce,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// waveform position
	output logic wave_valid,
	output logic [marker_pkg::SEG_W-1:0] wave_seg,
	output logic [marker_pkg::POS_W-1:0] wave_pos,
	// marker event outputs and level-hold window
	output logic [marker_pkg::NMARK-1:0] evt,
	output logic alc_sample
);
	function automatic logic [marker_pkg::IDX_W-1:0] mem_idx(
		input logic [marker_pkg::SEG_W-1:0] s,
		input logic [marker_pkg::POS_W-1:0] p);
		mem_idx = {s, p};
	endfunction

	function automatic logic [marker_pkg::POS_W-1:0] seg_last(
		input logic [31:0] lens,
		input logic [marker_pkg::SEG_W-1:0] s);
		seg_last = lens[s*marker_pkg::SEGLEN_STEP +: marker_pkg::POS_W];
	endfunction

	// bus address phase and data phase
	logic acc;
	logic wr_q;
	logic [7:0] ba_q;
	logic [31:0] rdata;
	logic [31:0] hrdata_q;
	logic w_ctrl;
	logic w_edit;
	logic w_range;
	logic w_seglen;
	logic w_seq;
	logic w_res;
	logic w_stat;

	// registers
	logic [31:0] ctrl_q;
	logic [31:0] range_q;
	logic [31:0] seglen_q;
	logic [marker_pkg::SEG_W-1:0] seq_last_q;
	logic [marker_pkg::NSEG*marker_pkg::NMARK-1:0] seq_en_q;
	logic [marker_pkg::NSEG-1:0] res_q;
	logic refused_q;

	// edit engine
	marker_pkg::ed_state_t st_q;
	marker_pkg::cmd_t cmd_q;
	marker_pkg::cmd_t cmd_w;
	logic [1:0] mark_q;
	logic [marker_pkg::SEG_W-1:0] eseg_q;
	logic [marker_pkg::SEG_W-1:0] eseg_w;
	logic [marker_pkg::POS_W-1:0] cur_q;
	logic [marker_pkg::POS_W-1:0] last_q;
	logic [marker_pkg::POS_W-1:0] skip_q;
	logic [marker_pkg::POS_W-1:0] cnt_q;
	logic [marker_pkg::POS_W-1:0] go_first;
	logic [marker_pkg::POS_W-1:0] go_last;
	logic [marker_pkg::POS_W-1:0] go_skip;
	logic ed_go;
	logic ed_refuse;
	logic busy;
	logic mem_we;
	logic set_bit;
	logic [marker_pkg::IDX_W-1:0] widx;
	logic [marker_pkg::NMARK-1:0] wold;

	// marker store and playback
	logic [marker_pkg::NMARK-1:0] mem_q [marker_pkg::NSEG*marker_pkg::NSAMP];
	logic play;
	logic seqm;
	logic [marker_pkg::SEG_W-1:0] ctrl_seg;
	logic [marker_pkg::SEG_W-1:0] seg_q;
	logic [marker_pkg::POS_W-1:0] pos_q;
	logic play_q;
	logic seg_end;
	logic [marker_pkg::SEG_W-1:0] seg_nx;
	logic [marker_pkg::NMARK-1:0] rd_q;
	logic rdv_q;
	logic [marker_pkg::NMARK-1:0] en_q;

	mark_if mk ();

	// bus slave: zero wait states while ce is high
	assign acc = hsel & htrans[1] & hready & ce;
	assign hreadyout = ce;
	assign hresp = marker_pkg::HRESP_OKAY;
	assign hrdata = hrdata_q;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wr_q <= 1'b0;
			ba_q <= '0;
			hrdata_q <= '0;
		end else if (ce) begin
			wr_q <= acc & hwrite;
			if (acc) ba_q <= haddr[7:0];
			if (acc & !hwrite) hrdata_q <= rdata;
		end
	end

	assign w_ctrl = wr_q && ba_q == marker_pkg::OFF_CTRL;
	assign w_edit = wr_q && ba_q == marker_pkg::OFF_EDIT;
	assign w_range = wr_q && ba_q == marker_pkg::OFF_RANGE;
	assign w_seglen = wr_q && ba_q == marker_pkg::OFF_SEGLEN;
	assign w_seq = wr_q && ba_q == marker_pkg::OFF_SEQ;
	assign w_res = wr_q && ba_q == marker_pkg::OFF_RES;
	assign w_stat = wr_q && ba_q == marker_pkg::OFF_STAT;

	always_comb begin
		rdata = '0;
		if (haddr[7:0] == marker_pkg::OFF_CTRL) begin
			rdata = ctrl_q;
		end else if (haddr[7:0] == marker_pkg::OFF_EDIT) begin
			rdata[marker_pkg::EDIT_CMD +: 2] = cmd_q;
			rdata[marker_pkg::EDIT_MARK +: 2] = mark_q;
			rdata[marker_pkg::EDIT_SEG +: marker_pkg::SEG_W] = eseg_q;
		end else if (haddr[7:0] == marker_pkg::OFF_RANGE) begin
			rdata = range_q;
		end else if (haddr[7:0] == marker_pkg::OFF_SEGLEN) begin
			rdata = seglen_q;
		end else if (haddr[7:0] == marker_pkg::OFF_SEQ) begin
			rdata[marker_pkg::SEQ_LAST +: marker_pkg::SEG_W] = seq_last_q;
			rdata[marker_pkg::SEQ_EN +: 16] = seq_en_q;
		end else if (haddr[7:0] == marker_pkg::OFF_RES) begin
			rdata[marker_pkg::NSEG-1:0] = res_q;
		end else if (haddr[7:0] == marker_pkg::OFF_STAT) begin
			rdata[marker_pkg::STAT_BUSY] = busy;
			rdata[marker_pkg::STAT_REFUSED] = refused_q;
			rdata[marker_pkg::STAT_SEG +: marker_pkg::SEG_W] = seg_q;
			rdata[marker_pkg::STAT_POS +: marker_pkg::POS_W] = pos_q;
			rdata[marker_pkg::STAT_EVT +: marker_pkg::NMARK] = evt;
		end
	end

	// configuration registers; a sequence register write reloads the segment enables too
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ctrl_q <= marker_pkg::CTRL_RST;
			range_q <= marker_pkg::RANGE_RST;
			seglen_q <= marker_pkg::SEGLEN_RST;
			seq_last_q <= marker_pkg::SEQ_LAST_RST;
			seq_en_q <= marker_pkg::SEQ_EN_RST;
			res_q <= marker_pkg::RES_RST;
		end else if (ce) begin
			if (w_ctrl) ctrl_q <= hwdata;
			if (w_range) range_q <= hwdata;
			if (w_seglen) seglen_q <= hwdata;
			if (w_seq) begin
				seq_last_q <= hwdata[marker_pkg::SEQ_LAST +: marker_pkg::SEG_W];
				seq_en_q <= hwdata[marker_pkg::SEQ_EN +: 16];
			end
			if (w_res) res_q <= hwdata[marker_pkg::NSEG-1:0];
		end
	end

	// refused edit flag: a new refusal wins over the clear
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			refused_q <= 1'b0;
		end else if (ce) begin
			if (ed_refuse) refused_q <= 1'b1;
			else if (w_stat && hwdata[marker_pkg::STAT_REFUSED])
				refused_q <= 1'b0;
		end
	end

	// edit command decode; skip is latched at apply time
	assign cmd_w = marker_pkg::cmd_t'(hwdata[marker_pkg::EDIT_CMD +: 2]);
	assign eseg_w = hwdata[marker_pkg::EDIT_SEG +: marker_pkg::SEG_W];
	assign busy = st_q == marker_pkg::ED_RUN;
	assign ed_go = w_edit && !busy && res_q[eseg_w];
	assign ed_refuse = w_edit && !ed_go;
	assign go_first = (cmd_w == marker_pkg::CMD_CLR_ALL ||
		cmd_w == marker_pkg::CMD_SET_FIRST) ? marker_pkg::POS_FIRST :
		range_q[marker_pkg::RANGE_FIRST +: marker_pkg::POS_W];
	assign go_last = (cmd_w == marker_pkg::CMD_CLR_ALL) ?
		marker_pkg::POS_MAX : (cmd_w == marker_pkg::CMD_SET_FIRST) ?
		marker_pkg::POS_FIRST :
		range_q[marker_pkg::RANGE_LAST +: marker_pkg::POS_W];
	assign go_skip = (cmd_w == marker_pkg::CMD_SET_RANGE) ?
		range_q[marker_pkg::RANGE_SKIP +: marker_pkg::POS_W] : '0;

	// one sample per cycle, only the selected marker bit changes
	assign set_bit = cmd_q == marker_pkg::CMD_SET_RANGE ||
		cmd_q == marker_pkg::CMD_SET_FIRST;
	assign mem_we = busy && (!set_bit || cnt_q == '0);
	assign widx = mem_idx(eseg_q, cur_q);
	assign wold = mem_q[widx];

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_q <= marker_pkg::ED_IDLE;
			cmd_q <= marker_pkg::CMD_SET_RANGE;
			mark_q <= '0;
			eseg_q <= '0;
			cur_q <= '0;
			last_q <= '0;
			skip_q <= '0;
			cnt_q <= '0;
		end else if (ce) begin
			case (st_q)
			marker_pkg::ED_IDLE: begin
				if (ed_go) begin
					st_q <= marker_pkg::ED_RUN;
					cmd_q <= cmd_w;
					mark_q <= hwdata[marker_pkg::EDIT_MARK +: 2];
					eseg_q <= eseg_w;
					cur_q <= go_first;
					last_q <= go_last;
					skip_q <= go_skip;
					cnt_q <= '0;
				end
			end
			marker_pkg::ED_RUN: begin
				if (cur_q == last_q) begin
					st_q <= marker_pkg::ED_IDLE;
				end else begin
					cur_q <= cur_q + 1'b1;
					cnt_q <= (cnt_q == skip_q) ? '0 : cnt_q + 1'b1;
				end
			end
			default: st_q <= marker_pkg::ED_IDLE;
			endcase
		end
	end

	// marker store: one bit per marker per sample
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < marker_pkg::NSEG*marker_pkg::NSAMP; i++)
				mem_q[i] <= '0;
		end else if (ce && mem_we) begin
			mem_q[widx][mark_q] <= set_bit;
		end
	end

	// playback position
	assign play = ctrl_q[marker_pkg::CTRL_PLAY];
	assign seqm = ctrl_q[marker_pkg::CTRL_SEQ];
	assign ctrl_seg = ctrl_q[marker_pkg::CTRL_SEG +: marker_pkg::SEG_W];
	assign seg_end = pos_q == seg_last(seglen_q, seg_q);
	assign seg_nx = !seqm ? ctrl_seg :
		(seg_q == seq_last_q) ? '0 : seg_q + 1'b1;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			play_q <= 1'b0;
			pos_q <= '0;
			seg_q <= '0;
		end else if (ce) begin
			play_q <= play;
			if (!play_q) begin
				pos_q <= marker_pkg::POS_FIRST;
				seg_q <= seqm ? '0 : ctrl_seg;
			end else if (seg_end) begin
				pos_q <= marker_pkg::POS_FIRST;
				seg_q <= seg_nx;
			end else begin
				pos_q <= pos_q + 1'b1;
			end
		end
	end
	assign wave_valid = play_q;
	assign wave_seg = seg_q;
	assign wave_pos = pos_q;

	// read stage: adds the first of two lag cycles
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rd_q <= '0;
			rdv_q <= 1'b0;
			en_q <= '0;
		end else if (ce) begin
			rd_q <= play_q ? mem_q[mem_idx(seg_q, pos_q)] : '0;
			rdv_q <= play_q;
			en_q <= seqm ? seq_en_q[seg_q*marker_pkg::NMARK +:
				marker_pkg::NMARK] : marker_pkg::ALL_MARK;
		end
	end

	assign mk.valid = rdv_q;
	assign mk.bits = rd_q;
	assign mk.en = en_q;
	assign mk.pol = ctrl_q[marker_pkg::CTRL_POL +: marker_pkg::NMARK];
	assign mk.route = ctrl_q[marker_pkg::CTRL_ROUTE +: marker_pkg::NMARK];

	// output stage: second lag cycle
	marker_out u_out (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.m(mk.sink),
		.evt(evt),
		.alc_sample(alc_sample)
	);

	or_keep_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ce && mem_we && set_bit |=>
		(mem_q[$past(widx)] & $past(wold)) == $past(wold))
		else $error("set lost an existing point");
	other_keep_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ce && mem_we |=> (mem_q[$past(widx)] | (4'h1 << $past(mark_q))) ==
		($past(wold) | (4'h1 << $past(mark_q))))
		else $error("edit touched another marker");
	range_end_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ce && busy && cur_q == last_q |=> !busy)
		else $error("range edit overran last index");
	first_pt_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ce && ed_go && cmd_w == marker_pkg::CMD_SET_FIRST |=>
		busy && cur_q == '0 && last_q == '0 ##1 !busy)
		else $error("set-first not on sample zero");
	skip_gap_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		busy && set_bit && cnt_q != '0 |-> !mem_we)
		else $error("skipped sample written");
	refuse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ce && w_edit && !res_q[eseg_w] |=> refused_q && st_q == $past(st_q))
		else $error("edit of non-resident segment taken");
	lag_two_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ce && play_q && mk.pol == '0 && mk.route == '0 ##1 ce ##1 ce |->
		evt == ($past(mem_q[mem_idx(seg_q, pos_q)], 2) & $past(en_q)))
		else $error("marker not two samples behind");
endmodule

// >>> tb/event_monitor.sv
`timescale 1ns/1ps
module event_monitor (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// waveform position and event outputs
	input wire logic wave_valid,
	input wire logic [marker_pkg::SEG_W-1:0] wave_seg,
	input wire logic [marker_pkg::POS_W-1:0] wave_pos,
	input wire logic [marker_pkg::NMARK-1:0] evt,
	input wire logic alc_sample
);
	logic [marker_pkg::NMARK-1:0] evt_seen [marker_pkg::NSEG][marker_pkg::NSAMP];
	logic alc_seen [marker_pkg::NSEG][marker_pkg::NSAMP];
	logic [8:0] d1_q;
	logic [8:0] d2_q;
	// positions delayed two samples to line up with the outputs
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			d1_q <= '0;
			d2_q <= '0;
		end else begin
			d1_q <= {wave_valid, wave_seg, wave_pos};
			d2_q <= d1_q;
			if (d2_q[8]) begin
				evt_seen[d2_q[7:6]][d2_q[5:0]] <= evt;
				alc_seen[d2_q[7:6]][d2_q[5:0]] <= alc_sample;
			end
		end
	end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic ref_clk, sys_rst, ce, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, wave_seg;
	logic [2:0] hsize;
	logic wave_valid, alc_sample;
	logic [5:0] wave_pos, f, l;
	logic [3:0] evt, pol_v, rt_v, e;
	logic [3:0] exp_mk [4][64];
	logic [15:0] en_v;
	int seed, err_count, num_checks;
	int cyc = 0;

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	marker_gen marker_gen_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.wave_valid(wave_valid), .wave_seg(wave_seg), .wave_pos(wave_pos),
		.evt(evt), .alc_sample(alc_sample));
	event_monitor event_monitor_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.wave_valid(wave_valid), .wave_seg(wave_seg), .wave_pos(wave_pos),
		.evt(evt), .alc_sample(alc_sample));

	task end_sim;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count = err_count + 1;
			end_sim;
		end
	end

	task check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		num_checks++;
		if (seen !== ex) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, ex, seen);
		end
	endtask

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		hsel <= 1'b1;
		htrans <= marker_pkg::HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 1000);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 1000);
		rd = hrdata;
	endtask

	function automatic logic new_bit(input logic old, input logic [1:0] c,
		input int p, input int fi, input int la, input int sk);
		logic in_r;
		in_r = p >= fi && p <= la;
		case (c)
			marker_pkg::CMD_SET_RANGE: return old | (in_r && (p - fi) % (sk + 1) == 0);
			marker_pkg::CMD_CLR_RANGE: return old & !in_r;
			marker_pkg::CMD_CLR_ALL: return 1'b0;
			default: return old | (p == 0);
		endcase
	endfunction

	task edit(input logic [1:0] c, input logic [1:0] mk, input logic [1:0] sg,
		input logic [5:0] fi, input logic [5:0] la, input logic [5:0] sk);
		int n;
		bus(1'b1, marker_pkg::OFF_RANGE, {10'h0, sk, 2'h0, la, 2'h0, fi});
		bus(1'b1, marker_pkg::OFF_EDIT, {26'h0, sg, mk, c});
		n = 0;
		do begin
			bus(1'b0, marker_pkg::OFF_STAT, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 100);
		for (int p = 0; p < 64; p++) begin
			exp_mk[sg][p][mk] = new_bit(exp_mk[sg][p][mk], c, p, fi, la, sk);
		end
	endtask

	task play(input logic sq, input logic [1:0] sg, input int cycles);
		bus(1'b1, marker_pkg::OFF_CTRL, {20'h0, rt_v, pol_v, sg, sq, 1'b1});
		repeat (cycles) @(posedge ref_clk);
		for (int s = 0; s < 4; s++) begin
			if (sq || s == sg) begin
				for (int p = 0; p < 64; p++) begin
					e = (exp_mk[s][p] & (sq ? en_v[s*4+:4] : 4'hf)) ^ pol_v;
					check("evt", {28'h0, event_monitor_i.evt_seen[s][p]}, {28'h0, e});
					check("alc", {31'h0, event_monitor_i.alc_seen[s][p]}, {31'h0, |(e & rt_v)});
				end
			end
		end
		bus(1'b1, marker_pkg::OFF_CTRL, 32'h0);
	endtask

	initial begin
		seed = 32'he44bbefb;
		err_count = 0;
		num_checks = 0;
		sys_rst = 1'b1;
		ce = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		rt_v = 4'h0;
		pol_v = 4'h0;
		en_v = 16'hffff;
		for (int s = 0; s < 4; s++) begin
			for (int p = 0; p < 64; p++) begin
				exp_mk[s][p] = 4'h0;
			end
		end
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		bus(1'b0, marker_pkg::OFF_CTRL, 32'h0);
		check("ctrl", rd, marker_pkg::CTRL_RST);
		bus(1'b0, marker_pkg::OFF_SEGLEN, 32'h0);
		check("seglen", rd, marker_pkg::SEGLEN_RST);
		bus(1'b0, marker_pkg::OFF_SEQ, 32'h0);
		check("seq", rd, {12'h0, marker_pkg::SEQ_EN_RST, 2'h0, marker_pkg::SEQ_LAST_RST});
		bus(1'b0, marker_pkg::OFF_RES, 32'h0);
		check("res", rd, {28'h0, marker_pkg::RES_RST});
		bus(1'b0, 8'h1c, 32'h0);
		check("unmapped", rd, 32'h0);
		check("hresp", {31'h0, hresp}, {31'h0, marker_pkg::HRESP_OKAY});
		edit(marker_pkg::CMD_SET_FIRST, 2'h1, 2'h0, 6'h00, 6'h00, 6'h00);
		edit(marker_pkg::CMD_SET_RANGE, 2'h0, 2'h0, 6'h0a, 6'h14, 6'h00);
		edit(marker_pkg::CMD_CLR_RANGE, 2'h0, 2'h0, 6'h0d, 6'h11, 6'h00);
		edit(marker_pkg::CMD_SET_RANGE, 2'h2, 2'h1, 6'h05, 6'h19, 6'h01);
		edit(marker_pkg::CMD_SET_RANGE, 2'h2, 2'h1, 6'h28, 6'h28, 6'h00);
		edit(marker_pkg::CMD_SET_RANGE, 2'h3, 2'h2, 6'h00, 6'h3f, 6'h00);
		edit(marker_pkg::CMD_CLR_ALL, 2'h3, 2'h2, 6'h00, 6'h00, 6'h00);
		for (int i = 0; i < 12; i++) begin
			f = $unsigned($random(seed)) % 64;
			l = f + $unsigned($random(seed)) % (64 - f);
			edit(i % 4, $random(seed), $random(seed), f, l, $random(seed) % 4);
		end
		bus(1'b1, marker_pkg::OFF_RES, 32'h7);
		bus(1'b1, marker_pkg::OFF_EDIT, {26'h0, 2'h3, 2'h0, 2'h3});
		bus(1'b0, marker_pkg::OFF_STAT, 32'h0);
		check("refused", {31'h0, rd[1]}, 32'h1);
		bus(1'b1, marker_pkg::OFF_STAT, 32'h2);
		bus(1'b1, marker_pkg::OFF_RES, 32'hf);
		for (int s = 0; s < 4; s++) begin
			pol_v = $random(seed);
			rt_v = $random(seed);
			play(1'b0, s, 70);
		end
		bus(1'b1, marker_pkg::OFF_CTRL, 32'h0000_00f0);
		repeat (4) @(posedge ref_clk);
		check("idle evt", {28'h0, evt}, 32'h0);
		en_v = $random(seed);
		bus(1'b1, marker_pkg::OFF_SEQ, {12'h0, en_v, 4'h3});
		for (int r = 0; r < 2; r++) begin
			pol_v = $random(seed);
			rt_v = $random(seed);
			play(1'b1, 2'h0, 264);
		end
		end_sim;
	end
endmodule
